// File: filter_if.sv
// Link between converter control and one sinc3 decimator
interface filter_if;
  logic                        modBit;
  logic                        clear;
  logic [7:0]                  decWord;
  logic [sdc_pkg::WORD_W-1:0]  outWord;
  logic                        outValid;

  modport filter (input modBit, clear, decWord, output outWord, outValid);
  modport ctrl   (output modBit, clear, decWord, input outWord, outValid);
endinterface

// File: ref_mod_model.sv
// Behavioural external reference source and modulator bitstreams
module ref_mod_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Scenario: 0 good, 1 below threshold, 2 at threshold, 3/4 pin open
  input  wire logic [2:0]  refMode,
  // Detector and modulator outputs
  output logic      [11:0] refDiffMv,
  output logic             refPosOpen,
  output logic             refNegOpen,
  output logic      [1:0]  modBit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;

  always_ff @(posedge clk) begin
    if (srst) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end

  // Three quarters density on primary, half on aux
  assign modBit     = {cnt[0], cnt != 2'h0};
  assign refDiffMv  = (refMode == 3'h1) ? 12'h12b : (refMode == 3'h2) ? 12'h12c : 12'h9c4;
  assign refPosOpen = refMode == 3'h3;
  assign refNegOpen = refMode == 3'h4;
endmodule

// File: sdc_pkg.sv
// Constants, register map and types for the reference detect and sinc filter block
package sdc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;
  localparam int ACC_W  = 36;
  localparam int NCH    = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL  = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_FILT  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STAT  = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_MASK  = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_DATA0 = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_DATA1 = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_OFF0  = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_GAIN0 = 12'h01c;
  localparam logic [ADDR_W-1:0] OFS_OFF1  = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_GAIN1 = 12'h024;

  // Control fields: ext ref select, converter enable, calibration mode
  localparam int CT_XSEL = 0;
  localparam int CT_EN   = 2;
  localparam int CT_CAL  = 4;

  // Status fields
  localparam int ST_RDY   = 0;
  localparam int ST_ERR   = 2;
  localparam int ST_NOREF = 4;
  localparam int STICKY_W = 4;

  // Filter word
  localparam logic [7:0] FILT_RESET = 8'h45;
  localparam logic [7:0] FILT_MIN   = 8'h0d;
  localparam logic [7:0] FILT_MAX   = 8'hff;
  localparam int         DEC_SHIFT  = 3;
  localparam int         DEC_W      = 11;
  localparam int         OUT_MSB    = 32;
  localparam logic [1:0] PRIME_N    = 2'h3;

  // Reference detect threshold in millivolts
  localparam logic [11:0] REF_MIN_MV = 12'h12c;

  localparam logic [WORD_W-1:0] ALL_ONES   = 16'hffff;
  localparam logic [WORD_W-1:0] GAIN_RESET = 16'h8000;

  typedef enum logic [1:0] {
    CAL_NONE   = 2'b00,
    CAL_OFFSET = 2'b01,
    CAL_GAIN   = 2'b10
  } cal_mode_t;

  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_CONV = 2'b01,
    CS_CAL  = 2'b10
  } conv_state_t;
endpackage

// File: sdc_ref_filter.sv
// Reference select/detect, sinc filtering, chop averaging and calibration control with APB registers
//
// Design decisions made here: the placing of the registers and the APB register port.
module sdc_ref_filter (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // APB slave
  input  wire logic [sdc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [sdc_pkg::DATA_W-1:0]    pwdata,
  output logic      [sdc_pkg::DATA_W-1:0]    prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Reference detect inputs
  input  wire logic [11:0]                   refDiffMv,
  input  wire logic                          refPosOpen,
  input  wire logic                          refNegOpen,
  // Modulator bitstreams, primary in bit 0
  input  wire logic [sdc_pkg::NCH-1:0]       modBit,
  // Analog reference routing and interrupt
  output logic      [sdc_pkg::NCH-1:0]       extRefSelect,
  output logic                               irq
);
  import sdc_pkg::*;

  function automatic logic [7:0] clampWord(input logic [7:0] w);
    clampWord = (w < FILT_MIN) ? FILT_MIN : w;
  endfunction

  function automatic logic [WORD_W-1:0] avgWord(input logic [WORD_W-1:0] a, input logic [WORD_W-1:0] b);
    logic [WORD_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    avgWord = s[WORD_W:1];
  endfunction

  logic [7:0]             filterWord;
  logic [NCH-1:0]         convEnable;
  logic                   refMissing;
  logic [STICKY_W-1:0]    sticky;
  logic [STICKY_W-1:0]    mask;
  logic [DATA_W-1:0]      readData;
  logic                   mapped;
  logic                   apbAccess, wrEv, rdEv;

  conv_state_t            state    [NCH];
  cal_mode_t              calMode  [NCH];
  logic [1:0]             chopCnt  [NCH];
  logic [WORD_W-1:0]      prevWord [NCH];
  logic [WORD_W-1:0]      dataWord [NCH];
  logic [WORD_W-1:0]      offCoef  [NCH];
  logic [WORD_W-1:0]      gainCoef [NCH];
  logic [NCH-1:0]         calBad;
  logic [NCH-1:0]         restart;

  logic [WORD_W-1:0]      fltWord  [NCH];
  logic [NCH-1:0]         fltValid;
  logic [NCH-1:0]         fltClear;
  logic [NCH-1:0]         resultEv;
  logic [NCH-1:0]         calReq;
  logic [NCH-1:0]         calEnd;
  logic [NCH-1:0]         calFail;
  logic [NCH-1:0]         refUsedBad;
  logic                   refBad;
  logic [STICKY_W-1:0]    setBits;

  // One sinc3 decimator per converter
  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    filter_if fIf ();
    sinc3_decimator uDec (
      .clk  (clk),
      .srst (srst),
      .port (fIf.filter)
    );
    assign fIf.modBit   = modBit[ch];
    assign fIf.clear    = fltClear[ch];
    assign fIf.decWord  = filterWord;
    assign fltWord[ch]  = fIf.outWord;
    assign fltValid[ch] = fIf.outValid;
  end

  // APB phases: one wait state, write and read-clear at completion
  assign apbAccess = psel && penable && !pready;
  assign wrEv      = psel && penable && pready && pwrite;
  assign rdEv      = psel && penable && pready && !pwrite;

  assign refBad = (refDiffMv < REF_MIN_MV) || refPosOpen || refNegOpen;

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      fltClear[ch]   = (state[ch] == CS_IDLE) || restart[ch];
      resultEv[ch]   = fltValid[ch] && (chopCnt[ch] != 2'h0);
      refUsedBad[ch] = refMissing && extRefSelect[ch];
      calReq[ch]     = wrEv && (paddr == OFS_CTRL) && pwdata[CT_EN + ch]
                       && (pwdata[CT_CAL + 2*ch +: 2] != CAL_NONE);
      calEnd[ch]     = resultEv[ch] && (state[ch] == CS_CAL);
      calFail[ch]    = calEnd[ch] && (calBad[ch] || refUsedBad[ch]);
    end
    setBits = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      setBits[ST_RDY + ch] = resultEv[ch] && (state[ch] != CS_IDLE);
      setBits[ST_ERR + ch] = calFail[ch];
    end
  end

  // Reference detect flag follows the detector
  always_ff @(posedge clk) begin
    if (srst) begin
      refMissing <= 1'b0;
    end else begin
      refMissing <= refBad;
    end
  end

  // Control, filter word and mask registers
  always_ff @(posedge clk) begin
    if (srst) begin
      extRefSelect <= '0;
      convEnable <= '0;
      filterWord <= FILT_RESET;
      mask <= '0;
    end else if (wrEv) begin
      case (paddr)
        OFS_CTRL: begin
          extRefSelect <= pwdata[CT_XSEL +: NCH];
          convEnable <= pwdata[CT_EN +: NCH];
        end
        OFS_FILT: filterWord <= clampWord(pwdata[7:0]);
        OFS_MASK: mask <= pwdata[STICKY_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Sticky status: read clears only what was read, a new event wins
  always_ff @(posedge clk) begin
    if (srst) begin
      sticky <= '0;
    end else if (rdEv && (paddr == OFS_STAT)) begin
      sticky <= (sticky & ~prdata[STICKY_W-1:0]) | setBits;
    end else begin
      sticky <= sticky | setBits;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |((sticky | setBits) & mask);
    end
  end

  // Per converter sequencing, chop averaging and calibration
  always_ff @(posedge clk) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (srst) begin
        state[ch] <= CS_IDLE;
        calMode[ch] <= CAL_NONE;
        chopCnt[ch] <= '0;
        prevWord[ch] <= '0;
        dataWord[ch] <= '0;
        offCoef[ch] <= '0;
        gainCoef[ch] <= GAIN_RESET;
        calBad[ch] <= 1'b0;
        restart[ch] <= 1'b0;
      end else begin
        restart[ch] <= 1'b0;
        if (fltValid[ch]) begin
          prevWord[ch] <= fltWord[ch];
          if (chopCnt[ch] != 2'h2) begin
            chopCnt[ch] <= chopCnt[ch] + 2'h1;
          end
        end
        if (calReq[ch]) begin
          state[ch] <= CS_CAL;
          calMode[ch] <= cal_mode_t'(pwdata[CT_CAL + 2*ch +: 2]);
          chopCnt[ch] <= '0;
          calBad[ch] <= 1'b0;
          restart[ch] <= 1'b1;
        end else begin
          case (state[ch])
            CS_IDLE: begin
              chopCnt[ch] <= '0;
              if (convEnable[ch]) begin
                state[ch] <= CS_CONV;
              end
            end
            CS_CONV: begin
              if (!convEnable[ch]) begin
                state[ch] <= CS_IDLE;
              end else if (resultEv[ch]) begin
                if (refUsedBad[ch]) begin
                  dataWord[ch] <= ALL_ONES;
                end else begin
                  dataWord[ch] <= avgWord(fltWord[ch], prevWord[ch]);
                end
              end
            end
            CS_CAL: begin
              if (refUsedBad[ch]) begin
                calBad[ch] <= 1'b1;
              end
              if (calEnd[ch]) begin
                if (!calFail[ch]) begin
                  if (calMode[ch] == CAL_OFFSET) begin
                    offCoef[ch] <= avgWord(fltWord[ch], prevWord[ch]);
                  end else begin
                    gainCoef[ch] <= avgWord(fltWord[ch], prevWord[ch]);
                  end
                end
                calMode[ch] <= CAL_NONE;
                state[ch] <= convEnable[ch] ? CS_CONV : CS_IDLE;
              end
            end
            default: state[ch] <= CS_IDLE;
          endcase
        end
      end
    end
  end

  // Read multiplexer
  always_comb begin
    readData = '0;
    mapped = 1'b1;
    case (paddr)
      OFS_CTRL: readData[7:0] = {calMode[1], calMode[0], convEnable, extRefSelect};
      OFS_FILT: readData[7:0] = filterWord;
      OFS_STAT: readData[ST_NOREF:0] = {refMissing, sticky};
      OFS_MASK: readData[STICKY_W-1:0] = mask;
      OFS_DATA0: readData[WORD_W-1:0] = dataWord[0];
      OFS_DATA1: readData[WORD_W-1:0] = dataWord[1];
      OFS_OFF0: readData[WORD_W-1:0] = offCoef[0];
      OFS_GAIN0: readData[WORD_W-1:0] = gainCoef[0];
      OFS_OFF1: readData[WORD_W-1:0] = offCoef[1];
      OFS_GAIN1: readData[WORD_W-1:0] = gainCoef[1];
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !mapped;
      if (apbAccess && !pwrite) begin
        prdata <= readData;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_filter_reset: assert property ($fell(srst) |-> filterWord == FILT_RESET)
    else $error("filter word not at reset value");
  a_filter_range: assert property (filterWord >= FILT_MIN)
    else $error("filter word below minimum");
  a_noref_set: assert property (refBad |=> refMissing)
    else $error("no-reference flag not set");
  a_noref_clear: assert property (!refBad ##1 !refBad |-> !refMissing)
    else $error("no-reference flag did not clear");
  a_data_forced: assert property (resultEv[0] && state[0] == CS_CONV && convEnable[0]
    && refMissing && extRefSelect[0] |=> dataWord[0] == ALL_ONES)
    else $error("result not forced to all ones");
  a_cal_block: assert property (calFail[0] |=> $stable(offCoef[0]) && $stable(gainCoef[0]))
    else $error("coefficients updated on failed calibration");
  a_cal_error: assert property (calFail[1] |=> sticky[ST_ERR + 1])
    else $error("aux calibration error flag not set");
  a_int_ref: assert property (wrEv && paddr == OFS_CTRL && !pwdata[CT_XSEL] |=> !extRefSelect[0])
    else $error("internal reference not routed");
  a_ref_hold: assert property (!(wrEv && paddr == OFS_CTRL) |=> $stable(extRefSelect))
    else $error("reference select changed without a write");
  a_apb_wait: assert property (apbAccess |=> pready ##1 !pready)
    else $error("apb answer timing");
  a_first_result: assert property (restart[0] |-> !resultEv[0] [*2])
    else $error("result before chop pair");

  c_cal_fail: cover property (calFail[0]);
  c_forced: cover property (resultEv[1] && refMissing && extRefSelect[1]);
  c_irq: cover property ($rose(irq));
endmodule

// File: sdc_ref_filter_tb.sv
// Self-checking testbench for the reference detect and sinc filter block
module sdc_ref_filter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;
  logic              clk;
  logic              srst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic              pready;
  logic              pslverr;
  logic              irq;
  logic              refPosOpen;
  logic              refNegOpen;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata;
  logic [DATA_W-1:0] prdata;
  logic [11:0]       refDiffMv;
  logic [NCH-1:0]    modBit;
  logic [NCH-1:0]    extRefSelect;
  logic [2:0]        refMode;
  int                errorCnt;
  int                nCompared;

  // Steady filter word for the three-quarter density stream at filter word 13
  localparam logic [31:0] STEADY_WORD = 32'((3 * (13 * 8) ** 3 / 4) >> (OUT_MSB + 1 - WORD_W));

  sdc_ref_filter sdc_ref_filter_inst (.clk(clk), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refDiffMv(refDiffMv), .refPosOpen(refPosOpen), .refNegOpen(refNegOpen),
    .modBit(modBit), .extRefSelect(extRefSelect), .irq(irq));
  ref_mod_model ref_mod_model_inst (.clk(clk), .srst(srst), .refMode(refMode), .refDiffMv(refDiffMv),
    .refPosOpen(refPosOpen), .refNegOpen(refNegOpen), .modBit(modBit));

  always #5 clk = ~clk;

  task automatic stopTest();
    $display("Compared %0d, mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      errorCnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge clk);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rdReg(input logic [11:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  // Waits for the interrupt, then reads and clears the status
  task automatic waitResult(output int c, output logic [31:0] st);
    c = 0;
    while (irq !== 1'b1 && c < 3000) begin
      @(posedge clk);
      c++;
    end
    check({31'h0, irq}, 32'h1);
    rdReg(OFS_STAT, st);
  endtask

  task automatic runCal(input logic [31:0] ctl, input int sh, output logic [31:0] st);
    int          n;
    logic [31:0] d;
    wrReg(OFS_CTRL, ctl);
    d = ctl;
    for (n = 0; d[sh +: 2] != 2'h0 && n < 5000; n++) rdReg(OFS_CTRL, d);
    check({31'h0, n < 5000}, 32'h1);
    rdReg(OFS_STAT, st);
  endtask

  task automatic testReset();
    logic [31:0] d;
    logic        e;
    check({30'h0, extRefSelect}, 32'h0);
    rdReg(OFS_FILT, d);
    check(d, 32'h45);
    rdReg(OFS_GAIN0, d);
    check(d, {16'h0, GAIN_RESET});
    rdReg(OFS_STAT, d);
    check(d, 32'h0);
    apb(1'b0, 12'h040, 32'h0, d, e);
    check({d[30:0], e}, 32'h1);
    $display("Reset test done");
  endtask

  task automatic testRefSel();
    for (int i = 3; i >= 0; i--) begin
      wrReg(OFS_CTRL, 32'(i));
      repeat (2) @(posedge clk);
      check({30'h0, extRefSelect}, 32'(i));
    end
    $display("Reference select test done");
  endtask

  task automatic testFilt();
    logic [7:0]  wv[5] = '{8'h05, 8'h0c, 8'h0d, 8'hff, 8'h45};
    logic [7:0]  ev[5] = '{8'h0d, 8'h0d, 8'h0d, 8'hff, 8'h45};
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      wrReg(OFS_FILT, {24'h0, wv[i]});
      rdReg(OFS_FILT, d);
      check(d, {24'h0, ev[i]});
    end
    $display("Filter word test done");
  endtask

  task automatic testDetect();
    logic [2:0]  m[6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h0};
    logic        b[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [31:0] d;
    for (int i = 0; i < 6; i++) begin
      refMode <= m[i];
      repeat (2) @(posedge clk);
      rdReg(OFS_STAT, d);
      check({31'h0, d[ST_NOREF]}, {31'h0, b[i]});
    end
    $display("Reference detect test done");
  endtask

  task automatic testConv();
    int          c;
    logic [31:0] d;
    wrReg(OFS_FILT, 32'h0d);
    wrReg(OFS_MASK, 32'h1);
    rdReg(OFS_STAT, d);
    wrReg(OFS_CTRL, 32'h5);
    waitResult(c, d);
    check({31'h0, c > 4 * 13 * 8 && c <= 5 * 13 * 8 + 8}, 32'h1);
    check({31'h0, d[ST_RDY]}, 32'h1);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rdReg(OFS_DATA0, d);
    check({31'h0, d[15:0] === ALL_ONES}, 32'h0);
    check(d, STEADY_WORD);
    refMode <= 3'h1;
    waitResult(c, d);
    waitResult(c, d);
    rdReg(OFS_DATA0, d);
    check(d, {16'h0, ALL_ONES});
    rdReg(OFS_STAT, d);
    check({31'h0, d[ST_NOREF]}, 32'h1);
    refMode <= 3'h0;
    repeat (3) waitResult(c, d);
    rdReg(OFS_DATA0, d);
    check({31'h0, d[15:0] === ALL_ONES}, 32'h0);
    wrReg(OFS_MASK, 32'h0);
    repeat (300) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wrReg(OFS_CTRL, 32'h0);
    $display("Conversion test done");
  endtask

  task automatic testCal();
    logic [31:0] d;
    logic [31:0] st;
    refMode <= 3'h1;
    runCal(32'h15, CT_CAL, st);
    check({31'h0, st[ST_ERR]}, 32'h1);
    rdReg(OFS_OFF0, d);
    check(d, 32'h0);
    runCal(32'h8a, CT_CAL + 2, st);
    check({31'h0, st[ST_ERR + 1]}, 32'h1);
    rdReg(OFS_GAIN1, d);
    check(d, {16'h0, GAIN_RESET});
    refMode <= 3'h0;
    repeat (2) @(posedge clk);
    runCal(32'h15, CT_CAL, st);
    check({31'h0, st[ST_ERR]}, 32'h0);
    rdReg(OFS_OFF0, d);
    check(d, STEADY_WORD);
    $display("Calibration test done");
  endtask

  initial begin
    clk = 1'b0;
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    refMode = 3'h0;
    errorCnt = 0;
    nCompared = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    testReset();
    testRefSel();
    testFilt();
    testDetect();
    testConv();
    testCal();
    stopTest();
  end

  initial begin
    // Tests take a few thousand cycles; allow 30000
    #300000;
    errorCnt++;
    $display("Error at %0t: watchdog expired", $time);
    stopTest();
  end
endmodule

// File: sinc3_decimator.sv
// Third-order sinc decimation filter for one modulator bitstream
module sinc3_decimator (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  srst,
  // Filter link
  filter_if.filter   port
);
  import sdc_pkg::*;

  logic [ACC_W-1:0] int1, int2, int3;
  logic [ACC_W-1:0] dly1, dly2, dly3;
  logic [ACC_W-1:0] comb1, comb2, comb3;
  logic [DEC_W-1:0] decCnt;
  logic [DEC_W-1:0] decLast;
  logic [1:0]       primeCnt;

  assign decLast = (DEC_W'(port.decWord) << DEC_SHIFT) - DEC_W'(1);

  always_comb begin
    comb1 = int3 - dly1;
    comb2 = comb1 - dly2;
    comb3 = comb2 - dly3;
  end

  // Integrators at modulator rate, combs at decimated rate
  always_ff @(posedge clk) begin
    if (srst || port.clear) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      decCnt <= '0;
      primeCnt <= '0;
      port.outWord <= '0;
      port.outValid <= 1'b0;
    end else begin
      int1 <= int1 + ACC_W'(port.modBit);
      int2 <= int2 + int1;
      int3 <= int3 + int2;
      port.outValid <= 1'b0;
      if (decCnt >= decLast) begin
        decCnt <= '0;
        dly1 <= int3;
        dly2 <= comb1;
        dly3 <= comb2;
        port.outWord <= comb3[OUT_MSB -: WORD_W];
        if (primeCnt == PRIME_N) begin
          port.outValid <= 1'b1;
        end else begin
          primeCnt <= primeCnt + 2'h1;
        end
      end else begin
        decCnt <= decCnt + DEC_W'(1);
      end
    end
  end

  a_dec_spacing: assert property (@(posedge clk) disable iff (srst)
    port.outValid |=> !port.outValid [*8])
    else $error("decimated outputs too close");
  a_clear_quiet: assert property (@(posedge clk) disable iff (srst)
    port.clear |=> !port.outValid)
    else $error("output while filter cleared");
endmodule
